/* File: brs_pkg.sv */
// brs_pkg: shared constants and types for the buck regulator sequencer
// assumes a 125 MHz system clock and a synchronous, supply-derived reset
package brs_pkg;

	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ    = 125;
	localparam int T_BIAS_US  = 250;
	localparam int T_DLY1_US  = 1000;
	localparam int T_DLY2_US  = 2000;
	localparam int T_DLY3_US  = 3000;
	localparam int T_BLANK_US = 65;
	// time per 5 mV step at the fastest slew setting (0.2 ms/V)
	localparam int T_STEP_US  = 1;
	localparam int STEP_CYC   = T_STEP_US * CLK_MHZ;
	localparam int CNT_W      = 20;

	// ------------------------------------------------------------
	// i2c target
	// ------------------------------------------------------------
	localparam logic [6:0] I2C_ADDR   = 7'h5B;
	localparam logic [7:0] ADDR_VOUT  = 8'h00;
	localparam logic [7:0] ADDR_CTL_ONE = 8'h01;
	localparam logic [7:0] ADDR_CTL_TWO = 8'h02;
	localparam logic [7:0] ADDR_STAT  = 8'h03;

	// ------------------------------------------------------------
	// reset values and voltage scale
	// ------------------------------------------------------------
	localparam logic [7:0]  VOUT_RST  = 8'h50;
	localparam logic [7:0]  CTL_ONE_RST = 8'h00;
	localparam logic [7:0]  CTL_TWO_RST = 8'h27;
	localparam logic [11:0] MV_BASE   = 12'h258;
	localparam logic [11:0] MV_KNEE   = 12'h500;
	localparam logic [7:0]  KNEE_CODE = 8'h44;
	localparam logic [11:0] MV_STEP   = 12'h005;

	typedef struct packed {
		logic [3:0] rsvd;
		logic [1:0] on_time_select;
		logic [1:0] en_delay;
	} brs_ctl_one_t;

	typedef struct packed {
		logic       forced_switching_bit;
		logic       full_duty_disable;
		logic       discharge_enable;
		logic       rsvd;
		logic [3:0] slew;
	} brs_ctl_two_t;

	// analog comparator flags, all active high
	typedef struct packed {
		logic input_undervoltage_lockout;
		logic fault;
		logic pg_rise;
		logic pg_fall;
		logic duty_max;
		logic vout_low;
	} brs_cmp_t;

	typedef enum logic [1:0] {
		S_OFF,
		S_DELAY,
		S_SOFT,
		S_REG
	} brs_state_t;

	typedef enum logic [2:0] {
		I_IDLE,
		I_ADDR,
		I_ACK,
		I_WDATA,
		I_RDATA,
		I_RACK
	} brs_i2c_t;

endpackage : brs_pkg

/* File: brs_sequencer.sv */
// brs_sequencer: enable, soft-start, power-ok and i2c control of a buck stage
// assumes pins are synchronous to clk, comparator flags are synchronised here; rst_n tracks
// the input-supply power-on reset so registers survive an enable drop
`timescale 1ns/1ps
module brs_sequencer
	import brs_pkg::*;
#(
	parameter logic [brs_pkg::CNT_W-1:0] BIAS_CYC  = brs_pkg::CNT_W'(brs_pkg::T_BIAS_US * brs_pkg::CLK_MHZ),
	parameter logic [brs_pkg::CNT_W-1:0] DLY1_CYC  = brs_pkg::CNT_W'(brs_pkg::T_DLY1_US * brs_pkg::CLK_MHZ),
	parameter logic [brs_pkg::CNT_W-1:0] DLY2_CYC  = brs_pkg::CNT_W'(brs_pkg::T_DLY2_US * brs_pkg::CLK_MHZ),
	parameter logic [brs_pkg::CNT_W-1:0] DLY3_CYC  = brs_pkg::CNT_W'(brs_pkg::T_DLY3_US * brs_pkg::CLK_MHZ),
	parameter logic [brs_pkg::CNT_W-1:0] BLANK_CYC = brs_pkg::CNT_W'(brs_pkg::T_BLANK_US * brs_pkg::CLK_MHZ)
)
(
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst_n,
	// control pins and variant strap
	input  wire logic              reg_on,
	input  wire logic              ext_range,
	input  wire brs_pkg::brs_cmp_t cmp_in,
	// i2c pins
	input  wire logic              scl_in,
	input  wire logic              sda_in,
	output logic                   sda_out,
	output logic                   sda_oe,
	// power stage controls
	output logic                   power_ok_output,
	output logic                   switch_en,
	output logic                   hs_latch_on,
	output logic                   discharge_on,
	output logic                   forced_pwm,
	output logic [1:0]             on_time_select,
	output logic [11:0]            ref_mv
);
	import brs_pkg::*;

	function automatic logic [11:0] code_to_mv(input logic [7:0] code, input logic ext);
		logic [11:0] c;
		c = {4'h0, code};
		if (!ext)
			code_to_mv = MV_BASE + MV_STEP * c;
		else if (code <= KNEE_CODE)
			code_to_mv = MV_BASE + (MV_STEP << 1) * c;
		else
			code_to_mv = MV_KNEE + (MV_STEP << 2) * (c - {4'h0, KNEE_CODE});
	endfunction : code_to_mv

	// ------------------------------------------------------------
	// comparator synchronisers
	// ------------------------------------------------------------
	brs_cmp_t cmp_m_reg;
	brs_cmp_t cmp_reg;
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			cmp_m_reg <= '0;
			cmp_reg   <= '0;
		end
		else
		begin
			cmp_m_reg <= cmp_in;
			cmp_reg   <= cmp_m_reg;
		end
	end

	// ------------------------------------------------------------
	// i2c target and registers
	// ------------------------------------------------------------
	logic [7:0] vout_code_reg;
	brs_ctl_one_t ctl_one_reg;
	brs_ctl_two_t ctl_two_reg;
	brs_i2c_t   i2c_reg;
	logic [7:0] shift_reg;
	logic [7:0] ptr_reg;
	logic [3:0] bits_reg;
	logic       rw_reg;
	logic       ptr_set_reg;
	logic       scl_q_reg;
	logic       sda_q_reg;
	brs_state_t state_reg;
	logic [11:0] ramp_reg;

	wire scl_rise   = scl_in & ~scl_q_reg;
	wire scl_fall   = ~scl_in & scl_q_reg;
	wire bus_start  = scl_in & scl_q_reg & sda_q_reg & ~sda_in;
	wire bus_stop   = scl_in & scl_q_reg & ~sda_q_reg & sda_in;
	wire [7:0] stat = {4'h0, hs_latch_on, power_ok_output, state_reg};
	logic [7:0] rd_data;

	always_comb
	begin
		unique case (ptr_reg)
			ADDR_VOUT:  rd_data = vout_code_reg;
			ADDR_CTL_ONE: rd_data = ctl_one_reg;
			ADDR_CTL_TWO: rd_data = ctl_two_reg;
			ADDR_STAT:  rd_data = stat;
			default:    rd_data = 8'h00;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			scl_q_reg <= 1'b1;
			sda_q_reg <= 1'b1;
		end
		else
		begin
			scl_q_reg <= scl_in;
			sda_q_reg <= sda_in;
		end
	end

	// registers only follow rst_n, never reg_on
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			vout_code_reg <= VOUT_RST;
			ctl_one_reg   <= CTL_ONE_RST;
			ctl_two_reg   <= CTL_TWO_RST;
			i2c_reg       <= I_IDLE;
			shift_reg     <= 8'h00;
			ptr_reg       <= 8'h00;
			bits_reg      <= 4'h0;
			rw_reg        <= 1'b0;
			ptr_set_reg   <= 1'b0;
			sda_oe        <= 1'b0;
			sda_out       <= 1'b0;
		end
		else if (cmp_reg.input_undervoltage_lockout)
		begin
			i2c_reg <= I_IDLE;
			sda_oe  <= 1'b0;
		end
		else if (bus_start)
		begin
			i2c_reg  <= I_ADDR;
			bits_reg <= 4'h0;
			sda_oe   <= 1'b0;
		end
		else if (bus_stop)
		begin
			i2c_reg <= I_IDLE;
			sda_oe  <= 1'b0;
		end
		else
		begin
			unique case (i2c_reg)
				I_IDLE: ;
				I_ADDR, I_WDATA:
				begin
					if (scl_rise && bits_reg != 4'h8)
					begin
						shift_reg <= {shift_reg[6:0], sda_in};
						bits_reg  <= bits_reg + 4'h1;
					end
					else if (scl_fall && bits_reg == 4'h8)
					begin
						bits_reg <= 4'h0;
						if (i2c_reg == I_ADDR)
						begin
							if (shift_reg[7:1] == I2C_ADDR)
							begin
								rw_reg      <= shift_reg[0];
								ptr_set_reg <= 1'b0;
								sda_oe      <= 1'b1;
								i2c_reg     <= I_ACK;
							end
							else
								i2c_reg <= I_IDLE;
						end
						else
						begin
							if (!ptr_set_reg)
							begin
								ptr_reg     <= shift_reg;
								ptr_set_reg <= 1'b1;
							end
							else
							begin
								unique case (ptr_reg)
									ADDR_VOUT:  vout_code_reg <= shift_reg;
									ADDR_CTL_ONE: ctl_one_reg <= shift_reg;
									ADDR_CTL_TWO: ctl_two_reg <= shift_reg;
									default: ;
								endcase
								ptr_reg <= ptr_reg + 8'h01;
							end
							sda_oe  <= 1'b1;
							i2c_reg <= I_ACK;
						end
					end
				end
				I_ACK:
				begin
					if (scl_fall)
					begin
						if (rw_reg)
						begin
							shift_reg <= {rd_data[6:0], 1'b0};
							sda_oe    <= ~rd_data[7];
							bits_reg  <= 4'h1;
							i2c_reg   <= I_RDATA;
						end
						else
						begin
							sda_oe  <= 1'b0;
							i2c_reg <= I_WDATA;
						end
					end
				end
				I_RDATA:
				begin
					if (scl_fall)
					begin
						if (bits_reg == 4'h8)
						begin
							sda_oe   <= 1'b0;
							ptr_reg  <= ptr_reg + 8'h01;
							i2c_reg  <= I_RACK;
						end
						else
						begin
							sda_oe    <= ~shift_reg[7];
							shift_reg <= {shift_reg[6:0], 1'b0};
							bits_reg  <= bits_reg + 4'h1;
						end
					end
				end
				I_RACK:
				begin
					// a nack from the host ends the read
					if (scl_rise)
						i2c_reg <= sda_in ? I_IDLE : I_ACK;
				end
				default: i2c_reg <= I_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// start-up sequence
	// ------------------------------------------------------------
	logic [CNT_W-1:0] dly_cnt_reg;
	logic [CNT_W-1:0] dly_sel;
	logic [11:0]      step_cnt_reg;
	logic [11:0]      target_mv;
	wire              stop_req = ~reg_on | cmp_reg.input_undervoltage_lockout | cmp_reg.fault;

	always_comb
	begin
		unique case (ctl_one_reg.en_delay)
			2'b00: dly_sel = BIAS_CYC;
			2'b01: dly_sel = DLY1_CYC;
			2'b10: dly_sel = DLY2_CYC;
			2'b11: dly_sel = DLY3_CYC;
		endcase
		target_mv = code_to_mv(vout_code_reg, ext_range);
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state_reg   <= S_OFF;
			dly_cnt_reg <= '0;
		end
		else if (stop_req)
		begin
			state_reg   <= S_OFF;
			dly_cnt_reg <= '0;
		end
		else
		begin
			unique case (state_reg)
				S_OFF: state_reg <= S_DELAY;
				S_DELAY:
				begin
					dly_cnt_reg <= dly_cnt_reg + 1'b1;
					if (dly_cnt_reg >= dly_sel - 1'b1)
						state_reg <= S_SOFT;
				end
				S_SOFT:
				begin
					if (ramp_reg == target_mv)
						state_reg <= S_REG;
				end
				S_REG: ;
			endcase
		end
	end

	// ramp moves 5 mV per (slew+1) us, so duration scales with target volts
	always_ff @(posedge clk)
	begin
		if (!rst_n || state_reg == S_OFF || state_reg == S_DELAY)
		begin
			ramp_reg     <= 12'h000;
			step_cnt_reg <= 12'h000;
		end
		else if (ramp_reg != target_mv)
		begin
			if (step_cnt_reg >= 12'(STEP_CYC) * ({8'h00, ctl_two_reg.slew} + 12'h001) - 12'h001)
			begin
				step_cnt_reg <= 12'h000;
				if (ramp_reg + MV_STEP <= target_mv)
					ramp_reg <= ramp_reg + MV_STEP;
				else if (ramp_reg > target_mv + MV_STEP)
					ramp_reg <= ramp_reg - MV_STEP;
				else
					ramp_reg <= target_mv;
			end
			else
				step_cnt_reg <= step_cnt_reg + 12'h001;
		end
		else
			step_cnt_reg <= 12'h000;
	end

	// ------------------------------------------------------------
	// power-ok with hysteresis and blanking
	// ------------------------------------------------------------
	logic [CNT_W-1:0] blank_cnt_reg;
	// comparator flags select the 91 or 87 percent threshold by pg state
	wire pg_cond = power_ok_output ? ~cmp_reg.pg_fall : cmp_reg.pg_rise;

	always_ff @(posedge clk)
	begin
		if (!rst_n || stop_req || state_reg != S_REG)
		begin
			power_ok_output <= 1'b0;
			blank_cnt_reg   <= '0;
		end
		else if (pg_cond == power_ok_output)
			blank_cnt_reg <= '0;
		else if (blank_cnt_reg >= BLANK_CYC - 1'b1)
		begin
			power_ok_output <= pg_cond;
			blank_cnt_reg   <= '0;
		end
		else
			blank_cnt_reg <= blank_cnt_reg + 1'b1;
	end

	// ------------------------------------------------------------
	// power stage controls
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!rst_n || stop_req)
		begin
			switch_en    <= 1'b0;
			hs_latch_on  <= 1'b0;
			forced_pwm   <= 1'b0;
			discharge_on <= rst_n & ~cmp_reg.input_undervoltage_lockout & ctl_two_reg.discharge_enable;
		end
		else
		begin
			switch_en    <= state_reg == S_SOFT || state_reg == S_REG;
			discharge_on <= 1'b0;
			forced_pwm   <= ctl_two_reg.forced_switching_bit;
			if (ctl_two_reg.full_duty_disable || !switch_en)
				hs_latch_on <= 1'b0;
			else if (cmp_reg.vout_low)
				hs_latch_on <= 1'b0;
			else if (cmp_reg.duty_max)
				hs_latch_on <= 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			on_time_select <= 2'b00;
			ref_mv         <= 12'h000;
		end
		else
		begin
			on_time_select <= ctl_one_reg.on_time_select;
			ref_mv         <= ramp_reg;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	pg_enable_low_a: assert property (!reg_on |=> !power_ok_output) else $error("power-ok high with enable low");
	bias_wait_a: assert property (state_reg == S_DELAY && dly_cnt_reg < BIAS_CYC - 1'b1 |=> !switch_en) else $error("switching before bias-up");
	pg_softstart_a: assert property (state_reg != S_REG |=> !power_ok_output) else $error("power-ok during soft-start");
	pg_blank_a: assert property ($rose(power_ok_output) |-> $past(blank_cnt_reg) == BLANK_CYC - 1'b1) else $error("power-ok rose unfiltered");
	input_undervoltage_lockout_off_a: assert property (cmp_reg.input_undervoltage_lockout |=> !switch_en && !power_ok_output && !hs_latch_on) else $error("active under lockout");
	ramp_step_a: assert property (ramp_reg != $past(ramp_reg) |-> step_cnt_reg == 12'h000) else $error("ramp moved off step");
	latch_dis_a: assert property (ctl_two_reg.full_duty_disable |=> !hs_latch_on) else $error("high-side latch while disabled");
	dischg_off_a: assert property (switch_en |-> !discharge_on) else $error("discharge while switching");
	fault_pg_a: assert property (cmp_reg.fault |=> !power_ok_output) else $error("power-ok high during fault");

endmodule : brs_sequencer

/* File: brs_host_model.sv */
// brs_host_model: i2c host that programs the sequencer registers
// assumes the device samples scl and sda on clk, >= 4 clk per scl phase
`timescale 1ns/1ps
module brs_host_model
#(
	parameter int HALF = 6
)
(
	// clock
	input  wire logic clk,
	// device side of the data line
	input  wire logic dev_sda_oe,
	input  wire logic dev_sda_out,
	// bus wires
	output logic      scl,
	output logic      sda
);
	logic host_low;

	// ------------------------------------------------------------
	// open-drain data wire, pulled up when nobody pulls low
	// ------------------------------------------------------------
	assign sda = ~(host_low | (dev_sda_oe & ~dev_sda_out));

	initial
	begin
		scl = 1'b1;
		host_low = 1'b0;
	end

	task automatic tick();
		repeat (HALF) @(posedge clk);
		#1;
	endtask : tick

	// data moves one cycle after scl falls, never while scl is high
	task automatic put_bit(input logic b, output logic r);
		@(posedge clk);
		#1;
		host_low = ~b;
		tick();
		scl = 1'b1;
		tick();
		r = sda;
		scl = 1'b0;
	endtask : put_bit

	task automatic start();
		logic r;
		put_bit(1'b1, r);
		host_low = 1'b0;
		scl = 1'b1;
		tick();
		host_low = 1'b1;
		tick();
		scl = 1'b0;
	endtask : start

	task automatic stop();
		logic r;
		put_bit(1'b0, r);
		scl = 1'b1;
		tick();
		host_low = 1'b0;
		tick();
	endtask : stop

	task automatic send(input logic [7:0] d, inout logic ok);
		logic r;
		for (int i = 7; i >= 0; i--)
			put_bit(d[i], r);
		put_bit(1'b1, r);
		ok = ok & ~r;
	endtask : send

	task automatic recv(output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			put_bit(1'b1, r);
			d[i] = r;
		end
		put_bit(1'b1, r);
	endtask : recv

	task automatic write_reg(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d, output logic ok);
		ok = 1'b1;
		start();
		send({a, 1'b0}, ok);
		send(p, ok);
		send(d, ok);
		stop();
	endtask : write_reg

	task automatic read_reg(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d, output logic ok);
		ok = 1'b1;
		start();
		send({a, 1'b0}, ok);
		send(p, ok);
		start();
		send({a, 1'b1}, ok);
		recv(d);
		stop();
	endtask : read_reg
endmodule : brs_host_model

/* File: tb.sv */
// tb: self-checking bench for brs_sequencer with short delay parameters
// assumes brs_host_model as i2c host; comparator flags driven here
`timescale 1ns/1ps
module tb;
	import brs_pkg::*;
	logic        clk;
	logic        rst_n;
	logic        reg_on;
	logic        ext_range;
	brs_cmp_t    cmp;
	logic        scl;
	logic        sda;
	logic        sda_out;
	logic        sda_oe;
	logic        pok;
	logic        sw_en;
	logic        hs_on;
	logic        dis_on;
	logic        fwd_sw;
	logic [1:0]  on_time;
	logic [11:0] ref_mv;
	logic [7:0]  rd;
	logic [7:0]  code;
	logic        ack;
	int          miscompares;
	int          tests_run;
	int          seed;
	int          n;
	int          t;
	int          dly [4] = '{20, 40, 60, 80};

	brs_sequencer #(.BIAS_CYC(20'h14), .DLY1_CYC(20'h28), .DLY2_CYC(20'h3C), .DLY3_CYC(20'h50),
		.BLANK_CYC(20'h0A)) i_dut (.clk(clk), .rst_n(rst_n), .reg_on(reg_on), .ext_range(ext_range),
		.cmp_in(cmp), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.power_ok_output(pok), .switch_en(sw_en), .hs_latch_on(hs_on), .discharge_on(dis_on),
		.forced_pwm(fwd_sw), .on_time_select(on_time), .ref_mv(ref_mv));
	brs_host_model i_host (.clk(clk), .dev_sda_oe(sda_oe), .dev_sda_out(sda_out), .scl(scl), .sda(sda));

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : cyc

	task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
		tests_run++;
		if (got !== exp)
		begin
			miscompares++;
			$display("BAD %s expected %0h seen %0h", what, exp, got);
		end
	endtask : check

	task automatic in_range(input string what, input int lo, input int hi, input int got);
		tests_run++;
		if (got < lo || got > hi)
		begin
			miscompares++;
			$display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask : in_range

	function automatic logic [11:0] mv(input logic [7:0] c, input logic x);
		if (!x)
			return 12'h258 + 12'(c) * 12'h005;
		if (c > 8'h44)
			return 12'h500 + 12'(c - 8'h44) * 12'h014;
		return 12'h258 + 12'(c) * 12'h00A;
	endfunction : mv

	function automatic logic pick(input int s);
		case (s)
			0: return sw_en;
			1: return pok;
			default: return hs_on;
		endcase
	endfunction : pick

	task automatic wait_sig(input int s, input logic v, input int lim, output int k);
		k = 0;
		while (pick(s) !== v && k < lim)
		begin
			cyc(1);
			k++;
		end
	endtask : wait_sig

	task automatic ramp(input logic [11:0] e, output int k);
		k = 0;
		while (ref_mv !== e && k < 20000)
		begin
			cyc(1);
			k++;
		end
		check("ramp target", e, ref_mv);
	endtask : ramp

	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		i_host.write_reg(I2C_ADDR, p, d, ack);
		check("write ack", 12'h001, {11'h000, ack});
	endtask : wr

	task automatic rdc(input logic [7:0] p, input logic [7:0] e);
		i_host.read_reg(I2C_ADDR, p, rd, ack);
		check("read ack", 12'h001, {11'h000, ack});
		check("read data", {4'h0, e}, {4'h0, rd});
	endtask : rdc

	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : complete_run

	// ------------------------------------------------------------
	// watchdog and main sequence
	// ------------------------------------------------------------
	initial
	begin
		repeat (90000) @(posedge clk);
		miscompares++;
		$display("BAD watchdog expected done seen timeout");
		complete_run();
	end

	initial
	begin
		seed = 80259;
		miscompares = 0;
		tests_run = 0;
		rst_n = 1'b0;
		reg_on = 1'b0;
		ext_range = 1'b0;
		cmp = '0;
		cyc(20);
		rst_n = 1'b1;
		cyc(3);
		rdc(ADDR_VOUT, VOUT_RST);
		rdc(ADDR_CTL_ONE, CTL_ONE_RST);
		rdc(ADDR_CTL_TWO, CTL_TWO_RST);
		i_host.write_reg(7'h5A, ADDR_VOUT, 8'h11, ack);
		check("foreign ack", 12'h000, {11'h000, ack});
		rdc(ADDR_VOUT, VOUT_RST);
		for (int i = 0; i < 4; i++)
		begin
			wr(ADDR_CTL_ONE, 8'(i));
			check("idle switching", 12'h000, {11'h000, sw_en});
			reg_on = 1'b1;
			wait_sig(0, 1'b1, 200, n);
			in_range("enable delay", dly[i] + 1, dly[i] + 5, n);
			reg_on = 1'b0;
			cyc(2);
			check("off state", 12'h001, {8'h00, pok, sw_en, hs_on, dis_on});
		end
		// fastest slew; full duty paired with longest on-time
		wr(ADDR_CTL_TWO, 8'h20);
		wr(ADDR_CTL_ONE, 8'h00);
		wr(ADDR_VOUT, 8'h00);
		cmp.pg_rise = 1'b1;
		reg_on = 1'b1;
		wait_sig(0, 1'b1, 200, n);
		n = 0;
		t = 0;
		while (ref_mv !== 12'h258 && n < 20000)
		begin
			t += int'(pok !== 1'b0);
			cyc(1);
			n++;
		end
		check("early power ok", 12'h000, 12'(t));
		in_range("soft-start time", 14800, 15200, n);
		wait_sig(1, 1'b1, 40, n);
		in_range("rise blanking", 9, 16, n);
		cmp.pg_rise = 1'b0;
		cyc(30);
		check("hysteresis", 12'h001, {11'h000, pok});
		cmp.pg_fall = 1'b1;
		cyc(4);
		cmp.pg_fall = 1'b0;
		cyc(20);
		check("short dip", 12'h001, {11'h000, pok});
		cmp.pg_fall = 1'b1;
		wait_sig(1, 1'b0, 40, n);
		in_range("fall blanking", 9, 16, n);
		cmp.pg_fall = 1'b0;
		cmp.pg_rise = 1'b1;
		wait_sig(1, 1'b1, 40, n);
		cmp.duty_max = 1'b1;
		wait_sig(2, 1'b1, 6, n);
		cmp.duty_max = 1'b0;
		cyc(5);
		check("latch held", 12'h001, {11'h000, hs_on});
		cmp.vout_low = 1'b1;
		wait_sig(2, 1'b0, 6, n);
		check("latch freed", 12'h000, {11'h000, hs_on});
		cmp.vout_low = 1'b0;
		wr(ADDR_CTL_TWO, 8'h60);
		cmp.duty_max = 1'b1;
		cyc(10);
		check("latch disabled", 12'h000, {11'h000, hs_on});
		cmp.duty_max = 1'b0;
		for (int i = 0; i < 3; i++)
		begin
			code = 8'($random(seed)) & 8'h0F;
			wr(ADDR_VOUT, code);
			ramp(mv(code, 1'b0), n);
		end
		ext_range = 1'b1;
		wr(ADDR_VOUT, 8'h45);
		ramp(mv(8'h45, 1'b1), n);
		wr(ADDR_CTL_TWO, 8'h61);
		wr(ADDR_VOUT, 8'h44);
		ramp(mv(8'h44, 1'b1), n);
		in_range("slew setting", 700, 1100, n);
		cmp.fault = 1'b1;
		cyc(4);
		check("fault drop", 12'h000, {10'h000, pok, sw_en});
		cmp.fault = 1'b0;
		wait_sig(0, 1'b1, 200, n);
		cmp.input_undervoltage_lockout = 1'b1;
		cyc(4);
		check("lockout", 12'h000, {9'h000, pok, sw_en, hs_on});
		i_host.read_reg(I2C_ADDR, ADDR_VOUT, rd, ack);
		check("lockout ack", 12'h000, {11'h000, ack});
		cmp.input_undervoltage_lockout = 1'b0;
		reg_on = 1'b0;
		cyc(3);
		rdc(ADDR_VOUT, 8'h44);
		for (int i = 0; i < 4; i++)
		begin
			wr(ADDR_CTL_ONE, {4'h0, 2'(i), 2'b00});
			check("on-time code", 12'(i), {10'h000, on_time});
		end
		// forced switching only shows while running; shutdown clears it
		wr(ADDR_CTL_TWO, 8'h80);
		reg_on = 1'b1;
		wait_sig(0, 1'b1, 200, n);
		cyc(2);
		check("forced, no discharge", 12'h002, {10'h000, fwd_sw, dis_on});
		reg_on = 1'b0;
		cyc(3);
		check("discharge disabled", 12'h000, {10'h000, fwd_sw, dis_on});
		complete_run();
	end
endmodule : tb
